// ===== rtl/port3_pkg.sv
/*
 Shared types and constants for the third port and reset pin block.
 Assumes a single 40 MHz core clock and no software-visible registers.
*/
package port3_pkg;
	localparam int PORT_WIDTH = 8;
	localparam int RESET_HOLD_CYCLES = 16;
	localparam logic [7:0] LATCH_RESET = 8'hff;
	localparam int HOLD_CNT_W = 8;
	localparam logic [7:0] PINS_IDLE = 8'hff;
	localparam logic [7:0] PINS_OFF = 8'h00;
	localparam int BIT_RXD = 0;
	localparam int BIT_TXD = 1;
	localparam int BIT_EXTERNAL_INTERRUPT_ZERO = 2;
	localparam int BIT_EXTERNAL_INTERRUPT_ONE = 3;
	localparam int BIT_CNT0 = 4;
	localparam int BIT_CNT1 = 5;
	localparam int BIT_WRS = 6;
	localparam int BIT_RDS = 7;

	// Alternate function outputs, each active low on the pin
	typedef struct packed {
		logic rd_strobe_n;
		logic wr_strobe_n;
		logic txd;
	} alt_out_t;

	// Alternate function inputs, synchronized pin levels
	typedef struct packed {
		logic timer1_count_input;
		logic timer0_count_input;
		logic external_interrupt_one;
		logic external_interrupt_zero;
		logic rxd;
	} alt_in_t;
endpackage

// ===== rtl/sync2.sv
/*
 Two-flop synchronizer for a bus of pin levels.
 Assumes inputs are asynchronous to clk.
*/
`timescale 1ns/100ps
module sync2 #(
	parameter int W = 8,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= INIT;
			q <= INIT;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// ===== rtl/port_three.sv
/*
 Quasi-bidirectional eight-bit third port with alternate functions,
 and the reset input pin filter.
 Assumes the core writes the latch over a simple strobe, and that the
 UART, timers, interrupt and memory logic sit outside this block.
*/
// Function
// [RULE1] Reset after sixteen consecutive high samples
// [RULE2] Latch one lets weak pull-up float pin
// [RULE3] Zero-to-one output gets one-cycle strong pull-up
// [RULE4] Bit zero carries UART receive input
// [RULE5] Bit one carries UART transmit output
// [RULE6] Bit two: interrupt zero, timer zero gate
// [RULE7] Bit three: interrupt one, timer one gate
// [RULE8] Bits four, five: timer count inputs
// [RULE9] Bit six drives external write strobe
// [RULE10] Bit seven drives external read strobe
// [RULE11] Pin low if latch or function low; the bit one transmit function only counts while UART_TX_ACTIVE is high
`timescale 1ns/100ps
module port_three #(
	parameter int HOLD = port3_pkg::RESET_HOLD_CYCLES
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Reset pin
	input wire logic RESET_PIN,
	output logic CORE_RESET,
	// Core side latch access
	input wire logic LATCH_WE,
	input wire logic [7:0] LATCH_WDATA,
	output logic [7:0] LATCH_Q,
	output logic [7:0] PIN_LEVEL,
	// Alternate functions
	input wire logic UART_TX_ACTIVE,
	input wire port3_pkg::alt_out_t ALT_OUT,
	output port3_pkg::alt_in_t ALT_IN,
	// Pins
	input wire logic [7:0] PORT_THREE_PINS_I,
	output logic [7:0] PORT_THREE_PINS_O,
	output logic [7:0] PORT_THREE_PINS_OE,
	output logic [7:0] PORT_THREE_STRONG_PU
);
	import port3_pkg::*;

	// ==========================================
	// Parameter checks
	// The hold counter has a fixed width, so HOLD must fit inside it
	if (HOLD < 1 || HOLD >= (1 << HOLD_CNT_W)) begin : g_hold_bad
		$error("HOLD out of range");
	end

	// ==========================================
	// Helpers
	// A pin goes low if either the latch or its function asks for low
	function automatic logic merge_low(input logic latch_bit, input logic func_bit);
		return latch_bit & func_bit;
	endfunction

	// Bits that were low last cycle and are high now
	function automatic logic [7:0] rising(input logic [7:0] now_v, input logic [7:0] was_v);
		return now_v & ~was_v;
	endfunction

	// ==========================================
	// Reset pin filter
	// Any low synchronized sample restarts the count, so short glitches never reset the core
	logic rst_sync;
	logic [HOLD_CNT_W-1:0] hold_cnt_q;
	logic [HOLD_CNT_W-1:0] hold_cnt_d;
	logic core_reset_q;
	logic core_reset_d;

	sync2 #(
		.W(1),
		.INIT(1'h0)
	) u_rst_sync (
		.clk(REF_CLK),
		.rst_n(NRST),
		.d(RESET_PIN),
		.q(rst_sync)
	);

	always_comb begin
		hold_cnt_d = hold_cnt_q;
		core_reset_d = 1'h0;
		if (!rst_sync) begin
			hold_cnt_d = '0;
		end else if (hold_cnt_q < HOLD_CNT_W'(HOLD)) begin
			hold_cnt_d = hold_cnt_q + HOLD_CNT_W'(1);
		end
		// Reset held while pin stays high after the count is reached
		if (rst_sync && hold_cnt_d >= HOLD_CNT_W'(HOLD)) begin
			core_reset_d = 1'h1; // RULE1
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			hold_cnt_q <= '0;
			core_reset_q <= 1'h0;
		end else begin
			hold_cnt_q <= hold_cnt_d;
			core_reset_q <= core_reset_d;
		end
	end

	// ==========================================
	// Port latch
	// Core reset wins over a write, so writes made during reset are lost
	logic [7:0] latch_q;
	logic [7:0] latch_d;

	always_comb begin
		latch_d = latch_q;
		if (core_reset_q) begin
			latch_d = LATCH_RESET; // RULE1
		end else if (LATCH_WE) begin
			latch_d = LATCH_WDATA; // RULE2
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			latch_q <= LATCH_RESET;
		end else begin
			latch_q <= latch_d;
		end
	end

	// ==========================================
	// Pin drive
	// Drive, strong pull-up and enable are all registered from next values,
	// so the pads see them change together with no combinational glitch
	logic [7:0] drive_q;
	logic [7:0] drive_d;
	logic [7:0] strong_q;
	logic [7:0] strong_d;
	logic [7:0] oe_q;
	logic [7:0] oe_d;

	always_comb begin
		// Functions idle high, so unused ones leave the latch in charge
		drive_d = latch_d; // RULE11
		if (UART_TX_ACTIVE) begin
			drive_d[BIT_TXD] = merge_low(latch_d[BIT_TXD], ALT_OUT.txd); // RULE5 RULE11
		end
		drive_d[BIT_WRS] = merge_low(latch_d[BIT_WRS], ALT_OUT.wr_strobe_n); // RULE9
		drive_d[BIT_RDS] = merge_low(latch_d[BIT_RDS], ALT_OUT.rd_strobe_n); // RULE10
		strong_d = rising(drive_d, drive_q); // RULE3
		// Weak pull-up is implied whenever the driver is off
		oe_d = ~drive_d | strong_d; // RULE2
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			drive_q <= LATCH_RESET;
			strong_q <= PINS_OFF;
			oe_q <= PINS_OFF;
		end else begin
			drive_q <= drive_d;
			strong_q <= strong_d;
			oe_q <= oe_d;
		end
	end

	// ==========================================
	// Pin sampling
	// Reads lag the pin by three clocks: two flops against metastability
	// and one register so that the output comes from a flop
	logic [7:0] pin_sync;
	logic [7:0] pin_level_q;
	logic [7:0] pin_level_d;

	sync2 #(
		.W(8),
		.INIT(PINS_IDLE)
	) u_pin_sync (
		.clk(REF_CLK),
		.rst_n(NRST),
		.d(PORT_THREE_PINS_I),
		.q(pin_sync)
	);

	always_comb begin
		pin_level_d = pin_sync; // RULE11
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			pin_level_q <= PINS_IDLE;
		end else begin
			pin_level_q <= pin_level_d;
		end
	end

	// ==========================================
	// Alternate inputs, taken from synchronized pin levels
	alt_in_t alt_in_q;
	alt_in_t alt_in_d;

	always_comb begin
		alt_in_d.rxd = pin_sync[BIT_RXD]; // RULE4
		alt_in_d.external_interrupt_zero = pin_sync[BIT_EXTERNAL_INTERRUPT_ZERO]; // RULE6
		alt_in_d.external_interrupt_one = pin_sync[BIT_EXTERNAL_INTERRUPT_ONE]; // RULE7
		alt_in_d.timer0_count_input = pin_sync[BIT_CNT0]; // RULE8
		alt_in_d.timer1_count_input = pin_sync[BIT_CNT1]; // RULE8
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			alt_in_q <= '1;
		end else begin
			alt_in_q <= alt_in_d;
		end
	end

	// ==========================================
	// Outputs
	assign PORT_THREE_PINS_O = drive_q;
	assign PORT_THREE_PINS_OE = oe_q;
	assign PORT_THREE_STRONG_PU = strong_q;
	assign LATCH_Q = latch_q;
	assign PIN_LEVEL = pin_level_q;
	assign ALT_IN = alt_in_q;
	assign CORE_RESET = core_reset_q;
endmodule

// ===== tb/pins_ext.sv
/* Board side of the third port: pull-ups and low drivers. Assumes one port. */
`timescale 1ns/100ps
module pins_ext (
	// Pad drive from the port
	input logic [7:0] PORT_THREE_PINS_O,
	input logic [7:0] PORT_THREE_PINS_OE,
	// Board drivers pulling pins low
	input logic [7:0] EXT_LOW,
	// Pin levels back to the port
	output logic [7:0] PORT_THREE_PINS_I
);
	assign PORT_THREE_PINS_I = ~(PORT_THREE_PINS_OE & ~PORT_THREE_PINS_O) & ~EXT_LOW;
endmodule

// ===== tb/port_three_asserts.sv
/* Checker for the third port. Assumes a bind onto port_three. */
`timescale 1ns/100ps
module port_three_asserts
	import port3_pkg::*;
#(parameter int HOLD = port3_pkg::RESET_HOLD_CYCLES) (
	input logic REF_CLK,
	input logic NRST,
	input logic RESET_PIN,
	input logic CORE_RESET,
	input logic [7:0] LATCH_Q,
	input logic UART_TX_ACTIVE,
	input alt_out_t ALT_OUT,
	input alt_in_t ALT_IN,
	input logic [7:0] PORT_THREE_PINS_I,
	input logic [7:0] PORT_THREE_PINS_O,
	input logic [7:0] PORT_THREE_PINS_OE,
	input logic [7:0] PORT_THREE_STRONG_PU
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	a_pu_pulse: assert property (PORT_THREE_STRONG_PU == (PORT_THREE_PINS_O & ~$past(PORT_THREE_PINS_O)))
		else $error("pullup");
	a_oe_drive: assert property (PORT_THREE_PINS_OE == (~PORT_THREE_PINS_O | PORT_THREE_STRONG_PU))
		else $error("enable");
	a_rst_latch: assert property (CORE_RESET |=> LATCH_Q == 8'hff) else $error("latch");
	a_rst_hold: assert property ($rose(CORE_RESET) |-> $past(RESET_PIN, HOLD)) else $error("hold");
	a_rst_end: assert property (!RESET_PIN [*5] |-> !CORE_RESET) else $error("release");
	a_wr_strobe: assert property (!ALT_OUT.wr_strobe_n |=> !PORT_THREE_PINS_O[6]) else $error("write");
	a_rd_strobe: assert property (!ALT_OUT.rd_strobe_n |=> !PORT_THREE_PINS_O[7]) else $error("read");
	a_txd_drive: assert property (UART_TX_ACTIVE && !ALT_OUT.txd |=> !PORT_THREE_PINS_O[1]) else $error("txd");
	a_alt_follow: assert property (ALT_IN == {$past(PORT_THREE_PINS_I[5:2], 3), $past(PORT_THREE_PINS_I[0], 3)})
		else $error("alternate input");
endmodule
bind port_three port_three_asserts #(.HOLD(HOLD)) u_chk(.*);

// ===== tb/testbench.sv
/* Bench for the third port. Assumes pins_ext as the board. */
`timescale 1ns/100ps
module testbench;
	import port3_pkg::*;
	logic REF_CLK = 0, NRST = 0, RESET_PIN = 0, LATCH_WE = 0, UART_TX_ACTIVE = 1, CORE_RESET;
	logic [7:0] LATCH_WDATA = 8'h00, EXT_LOW = 8'h00, LATCH_Q, PIN_LEVEL, PORT_THREE_PINS_I;
	logic [7:0] PORT_THREE_PINS_O, PORT_THREE_PINS_OE, PORT_THREE_STRONG_PU;
	alt_out_t ALT_OUT = 3'h7;
	alt_in_t ALT_IN;
	int failures = 0, checked = 0;
	logic [7:0] prev_drv = 8'hff, exp_drv;
	logic [23:0] rows [2] = '{24'h3c813c, 24'hff0ff0};
	port_three u_dut(.*);
	pins_ext u_pins(.*);
	initial forever #12.5 REF_CLK = ~REF_CLK;
	task automatic cyc(int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask
	task automatic chk(string nm, logic [7:0] s, e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_sim;
		$display("%0d checks %0d failures", checked, failures);
		if (failures == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		cyc(3000);
		failures++;
		end_sim;
	end
	initial begin
		cyc(10);
		NRST = 1;
		foreach (rows[i]) begin
			{LATCH_WDATA, EXT_LOW} = rows[i][23:8];
			LATCH_WE = 1;
			cyc(1);
			LATCH_WE = 0;
			cyc(4);
			chk("level", PIN_LEVEL, rows[i][7:0]);
			chk("alt_in", {3'h0, ALT_IN}, {3'h0, rows[i][5:2], rows[i][0]});
			chk("latch", LATCH_Q, rows[i][23:16]);
			chk("oe", PORT_THREE_PINS_OE, ~rows[i][23:16]);
		end
		for (int k = 0; k < 3; k++) begin
			ALT_OUT = ~(3'h1 << k);
			exp_drv = ~(8'h01 << (k ? k + 5 : 1));
			cyc(1);
			chk("drive", PORT_THREE_PINS_O, exp_drv);
			chk("strong", PORT_THREE_STRONG_PU, exp_drv & ~prev_drv);
			prev_drv = exp_drv;
		end
		// Transmit held low is ignored while the UART is idle
		UART_TX_ACTIVE = 0;
		ALT_OUT = 3'h6;
		cyc(1);
		chk("tx_idle", PORT_THREE_PINS_O, 8'hff);
		chk("strong", PORT_THREE_STRONG_PU, 8'h80);
		{UART_TX_ACTIVE, ALT_OUT} = 4'hf;
		cyc(1);
		chk("strong_end", PORT_THREE_STRONG_PU, 8'h00);
		chk("oe_idle", PORT_THREE_PINS_OE, 8'h00);
		RESET_PIN = 1;
		cyc(16);
		chk("early", {7'h0, CORE_RESET}, 8'h00);
		cyc(6);
		chk("reset", {7'h0, CORE_RESET}, 8'h01);
		{LATCH_WDATA, LATCH_WE} = 9'h001;
		cyc(1);
		LATCH_WE = 0;
		cyc(1);
		chk("refused", LATCH_Q, LATCH_RESET);
		RESET_PIN = 0;
		cyc(4);
		chk("release", {7'h0, CORE_RESET}, 8'h00);
		RESET_PIN = 1;
		cyc(10);
		RESET_PIN = 0;
		cyc(20);
		chk("short", {7'h0, CORE_RESET}, 8'h00);
		// Mid-run reset taken from a low latch, with the board released
		{LATCH_WDATA, LATCH_WE, EXT_LOW} = 17'h00100;
		cyc(1);
		LATCH_WE = 0;
		chk("low", PORT_THREE_PINS_OE, 8'hff);
		NRST = 0;
		cyc(4);
		chk("rst_latch", LATCH_Q, LATCH_RESET);
		chk("rst_oe", PORT_THREE_PINS_OE, 8'h00);
		chk("rst_level", PIN_LEVEL, 8'hff);
		NRST = 1;
		cyc(6);
		chk("rst_pins", PIN_LEVEL, 8'hff);
		end_sim;
	end
endmodule
